/* verilog/slhp_defines.vh */
// shared constants for the serial link host port
`ifndef SLHP_DEFINES_VH
`define SLHP_DEFINES_VH
`define SLHP_SEL_DATA 2'h0
`define SLHP_SEL_TXDATA 2'h1
`define SLHP_SEL_RXSTAT 2'h2
`define SLHP_SEL_TXSTAT 2'h3
`define SLHP_FLAG_BIT 0
`define SLHP_IE_BIT 1
`define SLHP_CLK_MHZ 250
`define SLHP_BIT_NS_10M 100
`define SLHP_BIT_NS_20M 50
`define SLHP_BIT_CYC_10M ((`SLHP_BIT_NS_10M * `SLHP_CLK_MHZ) / 1000)
`define SLHP_BIT_CYC_20M ((`SLHP_BIT_NS_20M * `SLHP_CLK_MHZ) / 1000)
`define SLHP_DATA_BITS 4'hb
`define SLHP_ACK_BITS 4'h2
`endif

/* verilog/slhp_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module slhp_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire d_i,
  output reg q_o
);
  reg meta_q;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_q <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // slhp_sync
`default_nettype wire

/* verilog/slhp_bit_timer.v */
// bit-time tick generator, restartable
`timescale 1ns/10ps
`default_nettype none
`include "slhp_defines.vh"
module slhp_bit_timer #(
  parameter CNT_W = 8
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire restart_i,
  input wire fast_i,
  output reg tick_o,
  output reg half_o
);
  reg [CNT_W-1:0] cnt_q;
  localparam integer BIT_FAST = `SLHP_BIT_CYC_20M;
  localparam integer BIT_SLOW = `SLHP_BIT_CYC_10M;
  wire [CNT_W-1:0] period;
  // a faster clock needs a wider CNT_W, else the period wraps
  assign period = fast_i ? BIT_FAST[CNT_W-1:0] : BIT_SLOW[CNT_W-1:0];
  always @(posedge clk_sys_i) begin
    if (reset_i || restart_i) begin
      cnt_q <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
      half_o <= 1'b0;
    end else begin
      tick_o <= (cnt_q == period - 1'b1);
      half_o <= (cnt_q == (period >> 1) - 1'b1);
      if (cnt_q == period - 1'b1)
        cnt_q <= {CNT_W{1'b0}};
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // slhp_bit_timer
`default_nettype wire

/* verilog/slhp_port.v */
// host port and serial link engine of the link adaptor
`timescale 1ns/10ps
`default_nettype none
`include "slhp_defines.vh"
module slhp_port (
  input wire clk_sys_i,
  input wire reset_i,
  input wire chip_select_n_i,
  input wire [1:0] register_select_i,
  input wire read_write_n_i,
  input wire [7:0] host_data_bus_i,
  output reg [7:0] host_data_bus_o,
  output reg host_data_bus_oe_o,
  output reg receive_int_o,
  output reg transmit_int_o,
  input wire serial_in_i,
  output reg serial_out_o,
  input wire link_rate_select_i
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire cs_n_s;
  wire rw_s;
  wire rate_s;
  wire rx_s;
  wire [1:0] sel_s;
  wire [7:0] wdata_s;
  slhp_sync #(.RESET_VAL(1'b1)) u_cs (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .d_i(chip_select_n_i), .q_o(cs_n_s));
  slhp_sync #(.RESET_VAL(1'b1)) u_rw (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .d_i(read_write_n_i), .q_o(rw_s));
  slhp_sync u_rate (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .d_i(link_rate_select_i), .q_o(rate_s));
  slhp_sync u_rx (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .d_i(serial_in_i), .q_o(rx_s));
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_sync
      wire din;
      wire dout;
      if (gi < 2) begin : g_sel
        assign din = register_select_i[gi];
        assign sel_s[gi] = dout;
      end else begin : g_dat
        assign din = host_data_bus_i[gi-2];
        assign wdata_s[gi-2] = dout;
      end
      slhp_sync u_s (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .d_i(din), .q_o(dout));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // host access decode
  reg cs_n_d1_q;
  reg [1:0] sel_q;
  reg rd_q;
  wire cs_fall;
  wire cs_rise;
  always @(posedge clk_sys_i) begin
    if (reset_i)
      cs_n_d1_q <= 1'b1;
    else
      cs_n_d1_q <= cs_n_s;
  end
  assign cs_fall = cs_n_d1_q & ~cs_n_s;
  assign cs_rise = ~cs_n_d1_q & cs_n_s;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sel_q <= 2'h0;
      rd_q <= 1'b1;
    end else if (cs_fall) begin
      sel_q <= sel_s;
      rd_q <= rw_s;
    end
  end
  // accesses act at the rising edge; invalid combinations fall through
  wire acc_rx_read;
  wire acc_tx_write;
  wire acc_rxst_wr;
  wire acc_txst_wr;
  assign acc_rx_read = cs_rise & rd_q & (sel_q == `SLHP_SEL_DATA);
  assign acc_tx_write = cs_rise & ~rd_q & (sel_q == `SLHP_SEL_TXDATA);
  assign acc_rxst_wr = cs_rise & ~rd_q & (sel_q == `SLHP_SEL_RXSTAT);
  assign acc_txst_wr = cs_rise & ~rd_q & (sel_q == `SLHP_SEL_TXSTAT);

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] rx_byte_q;
  reg [7:0] tx_byte_q;
  reg data_present_q;
  reg rx_ie_q;
  reg out_ready_q;
  reg tx_ie_q;
  reg rx_done;
  reg [7:0] rx_new;
  reg ack_rcvd;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      data_present_q <= 1'b0;
      rx_ie_q <= 1'b0;
      tx_ie_q <= 1'b0;
      out_ready_q <= 1'b1;
      rx_byte_q <= 8'h00;
      tx_byte_q <= 8'h00;
    end else begin
      // new byte wins over a simultaneous read
      if (rx_done) begin
        data_present_q <= 1'b1;
        rx_byte_q <= rx_new;
      end else if (acc_rx_read)
        data_present_q <= 1'b0;
      if (acc_tx_write) begin
        tx_byte_q <= wdata_s;
        out_ready_q <= 1'b0;
      end else if (ack_rcvd)
        out_ready_q <= 1'b1;
      if (acc_rxst_wr)
        rx_ie_q <= wdata_s[`SLHP_IE_BIT];
      if (acc_txst_wr)
        tx_ie_q <= wdata_s[`SLHP_IE_BIT];
    end
  end
  // no other access touches any state

  ////////////////////////////////////////////////////////////////////////
  // read bus and interrupts
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    case (sel_s)
      `SLHP_SEL_DATA: rd_mux = rx_byte_q;
      `SLHP_SEL_RXSTAT: rd_mux = {6'h00, rx_ie_q, data_present_q};
      `SLHP_SEL_TXSTAT: rd_mux = {6'h00, tx_ie_q, out_ready_q};
      `SLHP_SEL_TXDATA: rd_mux = 8'h00;
      default: rd_mux = 8'h00;
    endcase
  end
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      host_data_bus_o <= 8'h00;
      host_data_bus_oe_o <= 1'b0;
      receive_int_o <= 1'b0;
      transmit_int_o <= 1'b0;
    end else begin
      host_data_bus_o <= rd_mux;
      host_data_bus_oe_o <= ~cs_n_s & rw_s;
      receive_int_o <= rx_ie_q & data_present_q & ~acc_rx_read;
      transmit_int_o <= tx_ie_q & out_ready_q & ~acc_tx_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver: oversample at bit centres
  localparam RX_IDLE = 2'h0;
  localparam RX_BIT = 2'h1;
  localparam RX_STOP = 2'h2;
  // sample 0 is the start bit, 1 the kind bit, 2..9 the data bits
  localparam RX_KIND_IDX = 4'h1;
  localparam RX_LAST_IDX = 4'h9;
  reg [1:0] rx_st_q;
  reg [3:0] rx_cnt_q;
  reg [8:0] rx_sh_q;
  reg rx_restart;
  wire rx_tick;
  wire rx_half;
  slhp_bit_timer u_rxt (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .restart_i(rx_restart), .fast_i(rate_s), .tick_o(rx_tick),
    .half_o(rx_half));
  always @* begin
    rx_restart = (rx_st_q == RX_IDLE) & ~rx_s;
  end
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_done <= 1'b0;
      rx_new <= 8'h00;
      ack_rcvd <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      ack_rcvd <= 1'b0;
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_s) begin
            rx_st_q <= RX_BIT;
            rx_cnt_q <= 4'h0;
          end
        end
        RX_BIT: begin
          if (rx_half) begin
            // second bit: 1 means data, 0 means ack
            if (rx_cnt_q == RX_KIND_IDX && !rx_s) begin
              ack_rcvd <= 1'b1;
              rx_st_q <= RX_STOP;
            end else begin
              rx_sh_q <= {rx_s, rx_sh_q[8:1]};
              if (rx_cnt_q == RX_LAST_IDX) begin
                rx_done <= 1'b1;
                rx_new <= {rx_s, rx_sh_q[8:2]};
                rx_st_q <= RX_STOP;
              end
              rx_cnt_q <= rx_cnt_q + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (!rx_s)
            rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter; ack and data queued, one frame at a time
  localparam TX_IDLE = 2'h0;
  localparam TX_SEND = 2'h1;
  localparam TX_WAIT = 2'h2;
  reg [1:0] tx_st_q;
  reg ack_pend_q;
  reg dat_pend_q;
  reg [10:0] tx_sh_q;
  reg [3:0] tx_left_q;
  reg tx_restart;
  wire tx_tick;
  slhp_bit_timer u_txt (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .restart_i(tx_restart), .fast_i(rate_s), .tick_o(tx_tick),
    .half_o());
  // the timer runs while a frame waits, so the first bit leaves one bit
  // time after the request: an instant start would beat the minimum gap
  always @* begin
    tx_restart = (tx_st_q != TX_SEND) & ~ack_pend_q & ~dat_pend_q;
  end
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_st_q <= TX_IDLE;
      ack_pend_q <= 1'b0;
      dat_pend_q <= 1'b0;
      tx_sh_q <= 11'h000;
      tx_left_q <= 4'h0;
      serial_out_o <= 1'b0;
    end else begin
      if (acc_rx_read)
        ack_pend_q <= 1'b1;
      if (acc_tx_write)
        dat_pend_q <= 1'b1;
      case (tx_st_q)
        TX_IDLE: begin
          // ack first: it is short and frees the far sender
          if (ack_pend_q && tx_tick) begin
            ack_pend_q <= acc_rx_read;
            tx_sh_q <= 11'h001;
            tx_left_q <= `SLHP_ACK_BITS;
            serial_out_o <= 1'b1;
            tx_st_q <= TX_SEND;
          end else if (dat_pend_q && tx_tick) begin
            dat_pend_q <= acc_tx_write;
            tx_sh_q <= {1'b0, tx_byte_q, 2'h3};
            tx_left_q <= `SLHP_DATA_BITS;
            serial_out_o <= 1'b1;
            tx_st_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_tick) begin
            tx_sh_q <= {1'b0, tx_sh_q[10:1]};
            serial_out_o <= tx_sh_q[1];
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) begin
              serial_out_o <= 1'b0;
              tx_st_q <= TX_WAIT;
            end
          end
        end
        TX_WAIT: tx_st_q <= TX_IDLE;
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
endmodule // slhp_port
`default_nettype wire

/* sim/slhp_port_props.sv */
// assertion checker for the serial link host port
`timescale 1ns/10ps
`default_nettype none
module slhp_port_props (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic chip_select_n_i,
  input wire logic [1:0] register_select_i,
  input wire logic read_write_n_i,
  input wire logic [7:0] host_data_bus_i,
  input wire logic [7:0] host_data_bus_o,
  input wire logic host_data_bus_oe_o,
  input wire logic receive_int_o,
  input wire logic transmit_int_o,
  input wire logic serial_in_i,
  input wire logic serial_out_o,
  input wire logic link_rate_select_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic [8:0] in_q;
  logic [8:0] cs_q;
  // ages since the link input was high and since the host selected us
  always_ff @(posedge clk_sys_i) begin
    in_q <= (reset_i || serial_in_i) ? 9'h0 : in_q + {8'h0, ~&in_q};
    cs_q <= (reset_i || !chip_select_n_i) ? 9'h0 : cs_q + {8'h0, ~&cs_q};
  end
  ////////////////////////////////////////
  sequence s_end(logic [1:0] r, logic d);
    $rose(chip_select_n_i) && register_select_i == r && read_write_n_i == d;
  endsequence
  sequence s_start;
    ##1 !serial_out_o [*8] ##[12:45] serial_out_o;
  endsequence
  AST_OE_IDLE: assert property (chip_select_n_i [*8] |=> !host_data_bus_oe_o)
    else $error("bus driven while deselected");
  AST_OE_READ: assert property ($fell(chip_select_n_i) && read_write_n_i ##1
    (!chip_select_n_i && read_write_n_i) [*5] |=> host_data_bus_oe_o)
    else $error("bus not driven during read");
  AST_RX_CLR: assert property (s_end(2'h0, 1'b1) |-> ##[1:6] !receive_int_o)
    else $error("receive interrupt kept after data read");
  AST_TX_CLR: assert property (s_end(2'h1, 1'b0) |-> ##[1:6] !transmit_int_o)
    else $error("transmit interrupt kept after data write");
  AST_ACK_START: assert property (s_end(2'h0, 1'b1) && !link_rate_select_i
    |-> s_start) else $error("ack start outside window");
  AST_TX_START: assert property (s_end(2'h1, 1'b0) && !link_rate_select_i
    |-> s_start) else $error("data start outside window");
  AST_RESET: assert property (disable iff (1'b0) reset_i ##1 reset_i |->
    !serial_out_o && !receive_int_o && !transmit_int_o && !host_data_bus_oe_o)
    else $error("outputs active in reset");
  AST_RX_RISE: assert property ($rose(receive_int_o) |-> in_q < 9'd330 ||
    cs_q < 9'd12) else $error("receive interrupt without packet");
  AST_TX_RISE: assert property ($rose(transmit_int_o) |-> in_q < 9'd85 ||
    cs_q < 9'd12) else $error("transmit interrupt without ack");
endmodule // slhp_port_props
bind slhp_port slhp_port_props props_i (.clk_sys_i, .reset_i,
  .chip_select_n_i, .register_select_i, .read_write_n_i, .host_data_bus_i,
  .host_data_bus_o, .host_data_bus_oe_o, .receive_int_o, .transmit_int_o,
  .serial_in_i, .serial_out_o, .link_rate_select_i);
`default_nettype wire

/* sim/slhp_peer.sv */
// far-end link peer: sends bytes, acks bytes it receives
`timescale 1ns/10ps
`default_nettype none
module slhp_peer (
  input wire logic serial_out_i,
  output logic serial_in_o
);
  int bit_ns = 100;
  int bytes = 0;
  int acks = 0;
  logic [7:0] got;
  initial serial_in_o = 1'b0;
  task automatic send(input logic [10:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_o = b[i];
      #(bit_ns);
    end
    serial_in_o = 1'b0;
  endtask
  ////////////////////////////////////////
  // samples mid-bit; the second bit tells data from ack
  always begin
    @(posedge serial_out_i);
    #(bit_ns * 3 / 2);
    if (serial_out_i) begin
      for (int i = 0; i < 8; i++) begin
        #(bit_ns);
        got[i] = serial_out_i;
      end
      #(bit_ns);
      bytes++;
      send(11'h1, 2);
    end else begin
      acks++;
    end
  end
endmodule // slhp_peer
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the serial link host port
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic cs_n = 1'b1;
  logic [1:0] rs = 2'h0;
  logic rw = 1'b1;
  logic [7:0] wd = 8'h00;
  logic rate = 1'b0;
  wire logic [7:0] bus_o;
  wire logic oe, rx_int, tx_int, s_in, s_out;
  wire logic [7:0] din = oe ? bus_o : wd;
  int err_count = 0;
  int checks_done = 0;
  slhp_port dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .chip_select_n_i(cs_n), .register_select_i(rs), .read_write_n_i(rw),
    .host_data_bus_i(din), .host_data_bus_o(bus_o), .host_data_bus_oe_o(oe),
    .receive_int_o(rx_int), .transmit_int_o(tx_int), .serial_in_i(s_in),
    .serial_out_o(s_out), .link_rate_select_i(rate));
  slhp_peer peer (.serial_out_i(s_out), .serial_in_o(s_in));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic acc(input logic [1:0] r, input logic d, input logic [7:0] w,
                     output logic [7:0] q);
    rs = r;
    rw = d;
    wd = w;
    tick(1);
    cs_n = 1'b0;
    tick(6);
    q = bus_o;
    chk("bus enable", {7'h0, d}, {7'h0, oe});
    cs_n = 1'b1;
    tick(6);
    wd = ~w;
    chk("bus idle", 8'h0, {7'h0, oe});
  endtask
  task automatic wr(input logic [1:0] r, input logic [7:0] w);
    logic [7:0] q;
    acc(r, 1'b0, w, q);
  endtask
  task automatic rdc(input string n, input logic [1:0] r, input logic [7:0] e);
    logic [7:0] q;
    acc(r, 1'b1, 8'h00, q);
    chk(n, e, q);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    chk("reset pins", 8'h0, {5'h0, rx_int, tx_int, s_out});
    rdc("tx status", 2'h3, 8'h01);
    rdc("rx status", 2'h2, 8'h00);
  endtask
  task automatic t_status();
    wr(2'h2, 8'h02);
    rdc("rx status", 2'h2, 8'h02);
    chk("rx int", 8'h0, {7'h0, rx_int});
    wr(2'h3, 8'h02);
    rdc("tx status", 2'h3, 8'h03);
    chk("tx int", 8'h1, {7'h0, tx_int});
    rdc("tx data read", 2'h1, 8'h00);
    rdc("tx status", 2'h3, 8'h03);
    wr(2'h3, 8'h00);
    chk("tx int", 8'h0, {7'h0, tx_int});
  endtask
  task automatic t_link(input logic r, input logic [7:0] b, input logic [7:0] t);
    int n;
    rate = r;
    peer.bit_ns = r ? 50 : 100;
    wr(2'h2, 8'h02);
    fork peer.send({1'b0, b, 2'b11}, 11); join_none
    for (int i = 0; i < 13 * peer.bit_ns / 4 && rx_int !== 1'b1; i++) tick(1);
    chk("rx int", 8'h1, {7'h0, rx_int});
    wr(2'h2, 8'h00);
    chk("rx int", 8'h0, {7'h0, rx_int});
    wr(2'h2, 8'h02);
    chk("rx int", 8'h1, {7'h0, rx_int});
    wr(2'h0, ~b);
    rdc("rx status", 2'h2, 8'h03);
    n = peer.acks;
    rdc("rx byte", 2'h0, b);
    chk("rx int", 8'h0, {7'h0, rx_int});
    rdc("rx status", 2'h2, 8'h02);
    for (int i = 0; i < peer.bit_ns && peer.acks == n; i++) tick(1);
    chk("ack count", 8'(n + 1), 8'(peer.acks));
    wr(2'h3, 8'h02);
    wr(2'h1, t);
    chk("tx int", 8'h0, {7'h0, tx_int});
    rdc("tx status", 2'h3, 8'h02);
    for (int i = 0; i < 5 * peer.bit_ns && tx_int !== 1'b1; i++) tick(1);
    chk("tx int", 8'h1, {7'h0, tx_int});
    chk("link byte", t, peer.got);
    wr(2'h3, 8'h00);
    wr(2'h2, 8'h00);
  endtask
  ////////////////////////////////////////
  initial begin
    #400000;
    err_count++;
    give_verdict();
  end
  initial begin
    tick(4);
    reset_i = 1'b0;
    tick(3);
    t_reset();
    t_status();
    t_link(1'b0, 8'ha5, 8'h3c);
    t_link(1'b1, 8'h96, 8'hc3);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
